/* File: trs_pkg.sv */
// shared constants and types for the targeted neighbour refresh sequencer
package trs_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int TRS_CLK_PS             = 10000;
	localparam int TRS_ROW_ACTIVE_NS      = 40;
	localparam int TRS_PRECHARGE_NS       = 20;
	localparam int TRS_MODE_REG_DELAY_NS  = 20;
	// least times round up to whole cycles
	localparam int TRS_RAS_CYC   = (TRS_ROW_ACTIVE_NS * 1000 + TRS_CLK_PS - 1) / TRS_CLK_PS;
	localparam int TRS_RAS15_CYC = (3 * TRS_ROW_ACTIVE_NS * 1000 + 2 * TRS_CLK_PS - 1)
		/ (2 * TRS_CLK_PS);
	localparam int TRS_RP_CYC    = (TRS_PRECHARGE_NS * 1000 + TRS_CLK_PS - 1) / TRS_CLK_PS;
	localparam int TRS_MRD_CYC   = (TRS_MODE_REG_DELAY_NS * 1000 + TRS_CLK_PS - 1) / TRS_CLK_PS;

	// timer loads, one less than the spacing in cycles
	localparam int TRS_TMR_W = 8;
	localparam logic [TRS_TMR_W-1:0] TRS_LD_RAS    = TRS_TMR_W'(TRS_RAS_CYC - 1);
	localparam logic [TRS_TMR_W-1:0] TRS_LD_RAS15  = TRS_TMR_W'(TRS_RAS15_CYC - 1);
	localparam logic [TRS_TMR_W-1:0] TRS_LD_RP     = TRS_TMR_W'(TRS_RP_CYC - 1);
	localparam logic [TRS_TMR_W-1:0] TRS_LD_MRD    = TRS_TMR_W'(TRS_MRD_CYC - 1);
	localparam logic [TRS_TMR_W-1:0] TRS_LD_RP_MRD = TRS_TMR_W'(TRS_RP_CYC + TRS_MRD_CYC - 1);

	// ------------------------------------------------------------
	// targeted_refresh_control layout
	// ------------------------------------------------------------
	localparam int TRS_MR_EN_BIT   = 7;
	localparam int TRS_MR_BANK_LSB = 4;
	localparam int TRS_MR_UNL_BIT  = 3;
	localparam logic [7:0] TRS_MR_RESET = 8'h00;
	localparam logic [1:0] TRS_SEQ_LAST = 2'h2;  // index of the third activate/precharge
	localparam logic [1:0] TRS_SEQ_ALL  = 2'h3;
	localparam int TRS_ROW_W = 16;

	// ------------------------------------------------------------
	// controller register map and bus answers
	// ------------------------------------------------------------
	localparam logic [7:0] TRS_REG_CTRL   = 8'h00;
	localparam logic [7:0] TRS_REG_ROW    = 8'h04;
	localparam logic [7:0] TRS_REG_STATUS = 8'h08;
	localparam logic [7:0] TRS_REG_HITS   = 8'h0C;
	localparam logic [7:0] TRS_REG_LIMIT  = 8'h10;
	localparam logic [1:0] TRS_RESP_OKAY   = 2'h0;
	localparam logic [1:0] TRS_RESP_SLVERR = 2'h2;

	// link commands
	typedef enum logic [2:0] {TRS_NOP, TRS_ACT, TRS_PRE, TRS_PRECHARGE_EVERY_BANK, TRS_MRW, TRS_REF, TRS_SREF}
		trs_cmd_t;

endpackage

/* File: trs_link_if.sv */
// command link between the memory controller end and the device end
`timescale 1ns/1ps
interface trs_link_if
	import trs_pkg::*;
	#(parameter int ROW_W = TRS_ROW_W);

	logic             cmdValid;
	trs_cmd_t         cmdOp;
	logic [2:0]       cmdBank;
	logic [ROW_W-1:0] cmdRow;
	logic [7:0]       cmdOperand;
	logic [7:0]       modeReg;
	logic             modeActive;
	logic [15:0]      refreshCount;
	logic             restoreValid;
	logic [2:0]       restoreBank;
	logic [ROW_W-1:0] restoreRow;

	modport device (
		input  cmdValid, cmdOp, cmdBank, cmdRow, cmdOperand,
		output modeReg, modeActive, refreshCount, restoreValid, restoreBank, restoreRow
	);

	modport ctrl (
		output cmdValid, cmdOp, cmdBank, cmdRow, cmdOperand,
		input  modeReg, modeActive, refreshCount, restoreValid, restoreBank, restoreRow
	);

endinterface

/* File: trs_dev_end.sv */
// device end: targeted refresh control register and sequence tracking
`timescale 1ns/1ps
module trs_dev_end
	import trs_pkg::*;
	#(
		parameter int         ROW_W     = TRS_ROW_W,
		parameter logic [2:0] MAC_CODE  = 3'h1,
		parameter logic       UNLIMITED = 1'b0
	)
	(
		input wire logic      ref_clk,
		input wire logic      resetn,
		trs_link_if.device    link
	);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic                 en;
		logic [2:0]           bank;
		logic                 active;
		logic                 fin;
		logic [1:0]           actCnt;
		logic [1:0]           preCnt;
		logic [TRS_TMR_W-1:0] tmr;
		logic [ROW_W-1:0]     row;
		logic [15:0]          refCnt;
		logic                 restoreValid;
		logic [2:0]           restoreBank;
		logic [ROW_W-1:0]     restoreRow;
	} trs_dev_st_t;

	trs_dev_st_t s_r;
	trs_dev_st_t s_nxt;
	logic        bankHit;

	if (ROW_W < 1 || ROW_W > 16)
	begin : g_chk
		$error("row width must lie in 1..16");
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.restoreValid = 1'b0;
		bankHit = link.cmdBank == s_r.bank;
		// [RL8] self clear timer
		if (s_r.fin)
		begin
			if (s_r.tmr == '0)
			begin
				s_nxt.en = 1'b0;
				s_nxt.active = 1'b0;
				s_nxt.fin = 1'b0;
				// [RL22] victim rows restored
				s_nxt.restoreValid = 1'b1;
				s_nxt.restoreBank = s_r.bank;
				s_nxt.restoreRow = s_r.row;
			end
			else
				s_nxt.tmr = s_r.tmr - 1'b1;
		end
		if (link.cmdValid)
		begin
			unique case (link.cmdOp)
				TRS_MRW:
				begin
					// [RL9] exit ignores bank field
					if (!link.cmdOperand[TRS_MR_EN_BIT])
					begin
						s_nxt.en = 1'b0;
						s_nxt.active = 1'b0;
						s_nxt.fin = 1'b0;
						s_nxt.restoreValid = 1'b0;
					end
					// [RL3] unlimited part ignores enable
					else if (!s_r.active && !UNLIMITED)
					begin
						// [RL5] enable and bank select
						s_nxt.en = 1'b1;
						s_nxt.bank = link.cmdOperand[TRS_MR_BANK_LSB +: 3];
						s_nxt.active = 1'b1;
						s_nxt.actCnt = 2'h0;
						s_nxt.preCnt = 2'h0;
					end
				end
				TRS_ACT:
				begin
					// [RL10] count sequence activates
					if (s_r.active && bankHit && s_r.actCnt != TRS_SEQ_ALL)
					begin
						s_nxt.actCnt = s_r.actCnt + 1'b1;
						s_nxt.row = link.cmdRow;
					end
				end
				TRS_PRE, TRS_PRECHARGE_EVERY_BANK:
				begin
					// [RL10] precharge-all counts too
					if (s_r.active && (link.cmdOp == TRS_PRECHARGE_EVERY_BANK || bankHit)
						&& s_r.preCnt < s_r.actCnt)
					begin
						s_nxt.preCnt = s_r.preCnt + 1'b1;
						if (s_r.preCnt == TRS_SEQ_LAST)
						begin
							s_nxt.fin = 1'b1;
							s_nxt.tmr = TRS_LD_RP_MRD;
						end
					end
				end
				TRS_REF:
				begin
					// [RL19] only refresh commands advance it
					if (!s_r.active)
						s_nxt.refCnt = s_r.refCnt + 1'b1;
				end
				default:
				begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// [RL23] reset leaves mode disabled
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	// readback holds the fixed count field and unlimited flag
	assign link.modeReg      = {s_r.en, s_r.bank, UNLIMITED, MAC_CODE};
	assign link.modeActive   = s_r.active;
	assign link.refreshCount = s_r.refCnt;
	assign link.restoreValid = s_r.restoreValid;
	assign link.restoreBank  = s_r.restoreBank;
	assign link.restoreRow   = s_r.restoreRow;

endmodule

/* File: trs_ctrl_end.sv */
// controller end: register slave and targeted refresh command sequencer
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
// Functional notes
// [RL1] activate limit spans two refresh windows
// [RL2] at limit refresh fully or run sequence
// [RL3] unlimited count means no sequence needed
// [RL4] both aggressors together stay under limit
// [RL5] bit 7 enables, bits 6:4 bank
// [RL6] mode stays off during initialization
// [RL7] enter from idle, only exit write
// [RL8] device clears after third precharge, delay
// [RL9] explicit exit write ignores bank field
// [RL10] three activates, three precharges, precharge-all counts
// [RL11] entry write keeps other bits unchanged
// [RL12] wait delay, then bank activate/precharge only
// [RL13] other banks idle 1.5 active plus precharge
// [RL14] first precharge after 1.5 active time
// [RL15] second precharge one active time later
// [RL16] third precharge, complete after precharge+delay
// [RL17] interrupt: clear, three precharges, rerun
// [RL18] no refresh, no self refresh meanwhile
// [RL19] sequence activates leave refresh counter
// [RL20] new sequence waits delay plus precharge
// [RL21] sequence activates count in window budget
// [RL22] device restores degraded victim rows
// [RL23] reset leaves mode disabled
module trs_ctrl_end
	import trs_pkg::*;
	#(
		parameter int ROW_W  = TRS_ROW_W,
		parameter int ADDR_W = 8
	)
	(
		input  wire logic              ref_clk,
		input  wire logic              resetn,
		trs_link_if.ctrl               link,
		input  wire logic [ADDR_W-1:0] s_axi_awaddr,
		input  wire logic              s_axi_awvalid,
		output logic                   s_axi_awready,
		input  wire logic [31:0]       s_axi_wdata,
		input  wire logic [3:0]        s_axi_wstrb,
		input  wire logic              s_axi_wvalid,
		output logic                   s_axi_wready,
		output logic [1:0]             s_axi_bresp,
		output logic                   s_axi_bvalid,
		input  wire logic              s_axi_bready,
		input  wire logic [ADDR_W-1:0] s_axi_araddr,
		input  wire logic              s_axi_arvalid,
		output logic                   s_axi_arready,
		output logic [31:0]            s_axi_rdata,
		output logic [1:0]             s_axi_rresp,
		output logic                   s_axi_rvalid,
		input  wire logic              s_axi_rready
	);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef enum logic [2:0] {C_IDLE, C_MRD, C_RAS, C_RP, C_END, C_ABT_MRD, C_ABT_PRE}
		trs_seq_t;

	typedef struct packed {
		trs_seq_t             st;
		logic [TRS_TMR_W-1:0] tmr;
		logic [1:0]           step;
		logic [1:0]           abtCnt;
		logic [2:0]           seqBank;
		logic [ROW_W-1:0]     seqRow;
		logic                 awHeld;
		logic [ADDR_W-1:0]    awAddr;
		logic                 wHeld;
		logic [31:0]          wData;
		logic [3:0]           wStrb;
		logic                 awRdy;
		logic                 wRdy;
		logic                 bValid;
		logic [1:0]           bResp;
		logic                 arRdy;
		logic                 rValid;
		logic [31:0]          rData;
		logic [1:0]           rResp;
		logic [2:0]           ctlBank;
		logic                 initDone;
		logic [ROW_W-1:0]     rowReg;
		logic [15:0]          hits;
		logic [15:0]          limit;
		logic                 done;
		logic                 aborted;
		logic                 startReq;
		logic                 abortReq;
		logic                 cmdValid;
		trs_cmd_t             cmdOp;
		logic [2:0]           cmdBank;
		logic [ROW_W-1:0]     cmdRow;
		logic [7:0]           cmdOperand;
	} trs_ctrl_st_t;

	trs_ctrl_st_t s_r;
	trs_ctrl_st_t s_nxt;
	logic         wrFire;
	logic         unlimited;
	logic         autoHit;
	logic         goStart;
	logic [31:0]  wMerged;
	logic [31:0]  oldVal;

	if (ROW_W < 1 || ROW_W > 16 || ADDR_W < 5 || ADDR_W > 8)
	begin : g_chk
		$error("row width 1..16 and address width 5..8 only");
	end

	// byte-lane merge of a register write
	function automatic logic [31:0] trsMerge(
		input logic [31:0] oldW,
		input logic [31:0] newW,
		input logic [3:0]  strb
	);
		logic [31:0] res;
		res = oldW;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				res[8*i +: 8] = newW[8*i +: 8];
		return res;
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.cmdValid = 1'b0;
		s_nxt.cmdOp = TRS_NOP;
		// [RL3] unlimited count needs no sequence
		unlimited = link.modeReg[TRS_MR_UNL_BIT] && link.modeReg[2:0] == 3'h0;
		// [RL1] [RL2] [RL4] combined aggressor hits at limit
		autoHit = s_r.limit != 16'h0000 && s_r.hits >= s_r.limit;
		// [RL6] nothing starts before init done
		goStart = (s_r.startReq || autoHit) && s_r.initDone && !unlimited;
		wrFire = s_r.awHeld && s_r.wHeld && !s_r.bValid;
		oldVal = 32'h0000_0000;
		// idle drops old requests before a new write lands, so a start is not lost
		if (s_r.st == C_IDLE)
		begin
			s_nxt.startReq = 1'b0;
			s_nxt.abortReq = 1'b0;
		end

		// address and data taken in either order
		if (s_r.awRdy && s_axi_awvalid)
		begin
			s_nxt.awHeld = 1'b1;
			s_nxt.awAddr = s_axi_awaddr;
		end
		if (s_r.wRdy && s_axi_wvalid)
		begin
			s_nxt.wHeld = 1'b1;
			s_nxt.wData = s_axi_wdata;
			s_nxt.wStrb = s_axi_wstrb;
		end
		if (s_r.bValid && s_axi_bready)
			s_nxt.bValid = 1'b0;

		// register write once both halves are held
		unique case (s_r.awAddr)
			TRS_REG_CTRL:  oldVal = {25'h0, s_r.ctlBank, 1'b0, s_r.initDone, 2'h0};
			TRS_REG_ROW:   oldVal = 32'(s_r.rowReg);
			TRS_REG_HITS:  oldVal = {16'h0000, s_r.hits};
			TRS_REG_LIMIT: oldVal = {16'h0000, s_r.limit};
			default:       oldVal = 32'h0000_0000;
		endcase
		wMerged = trsMerge(oldVal, s_r.wData, s_r.wStrb);
		if (wrFire)
		begin
			s_nxt.awHeld = 1'b0;
			s_nxt.wHeld = 1'b0;
			s_nxt.bValid = 1'b1;
			s_nxt.bResp = TRS_RESP_OKAY;
			unique case (s_r.awAddr)
				TRS_REG_CTRL:
				begin
					// start and abort are one-shot requests
					s_nxt.startReq = s_nxt.startReq | (s_r.wStrb[0] & s_r.wData[0]);
					s_nxt.abortReq = s_nxt.abortReq | (s_r.wStrb[0] & s_r.wData[1]);
					s_nxt.initDone = wMerged[2];
					if (s_r.wStrb[0] && s_r.wData[3])
						s_nxt.done = 1'b0;
					s_nxt.ctlBank = wMerged[6:4];
				end
				TRS_REG_ROW:    s_nxt.rowReg = wMerged[ROW_W-1:0];
				TRS_REG_HITS:   s_nxt.hits = wMerged[15:0];
				TRS_REG_LIMIT:  s_nxt.limit = wMerged[15:0];
				TRS_REG_STATUS: s_nxt.bResp = TRS_RESP_OKAY;
				default:        s_nxt.bResp = TRS_RESP_SLVERR;
			endcase
		end
		s_nxt.awRdy = !s_nxt.awHeld && !s_nxt.bValid;
		s_nxt.wRdy = !s_nxt.wHeld && !s_nxt.bValid;

		// read channel, one outstanding
		if (s_r.arRdy && s_axi_arvalid)
		begin
			s_nxt.rValid = 1'b1;
			s_nxt.rResp = TRS_RESP_OKAY;
			unique case (s_axi_araddr)
				TRS_REG_CTRL:  s_nxt.rData = {25'h0, s_r.ctlBank, 1'b0, s_r.initDone, 2'h0};
				TRS_REG_ROW:   s_nxt.rData = 32'(s_r.rowReg);
				TRS_REG_STATUS:
					s_nxt.rData = {link.refreshCount, link.modeReg, 4'h0, unlimited,
						s_r.aborted, s_r.done, s_r.st != C_IDLE};
				TRS_REG_HITS:  s_nxt.rData = {16'h0000, s_r.hits};
				TRS_REG_LIMIT: s_nxt.rData = {16'h0000, s_r.limit};
				default:
				begin
					s_nxt.rData = 32'h0000_0000;
					s_nxt.rResp = TRS_RESP_SLVERR;
				end
			endcase
		end
		else if (s_r.rValid && s_axi_rready)
			s_nxt.rValid = 1'b0;
		s_nxt.arRdy = !s_nxt.rValid;

		// [RL17] interrupt: clear enable first
		if (s_r.abortReq && (s_r.st == C_MRD || s_r.st == C_RAS || s_r.st == C_RP))
		begin
			s_nxt.abortReq = 1'b0;
			s_nxt.aborted = 1'b1;
			s_nxt.cmdValid = 1'b1;
			s_nxt.cmdOp = TRS_MRW;
			s_nxt.cmdOperand = {1'b0, s_r.seqBank, link.modeReg[3:0]};
			s_nxt.tmr = TRS_LD_MRD;
			s_nxt.st = C_ABT_MRD;
		end
		else
		begin
			unique case (s_r.st)
				C_IDLE:
				begin
					// [RL7] entry only from idle
					if (goStart)
					begin
						// [RL11] entry write keeps low bits
						s_nxt.cmdValid = 1'b1;
						s_nxt.cmdOp = TRS_MRW;
						s_nxt.cmdOperand = {1'b1, s_r.ctlBank, link.modeReg[3:0]};
						s_nxt.seqBank = s_r.ctlBank;
						s_nxt.seqRow = s_r.rowReg;
						s_nxt.step = 2'h0;
						s_nxt.aborted = 1'b0;
						s_nxt.tmr = TRS_LD_MRD;
						s_nxt.st = C_MRD;
					end
				end
				C_MRD:
				begin
					// [RL12] silent until delay passes
					if (s_r.tmr == '0)
					begin
						// [RL13] first activate, busy blocks others
						s_nxt.cmdValid = 1'b1;
						s_nxt.cmdOp = TRS_ACT;
						s_nxt.cmdBank = s_r.seqBank;
						s_nxt.cmdRow = s_r.seqRow;
						s_nxt.tmr = TRS_LD_RAS15;
						s_nxt.st = C_RAS;
					end
					else
						s_nxt.tmr = s_r.tmr - 1'b1;
				end
				C_RAS:
				begin
					if (s_r.tmr == '0)
					begin
						// [RL14] [RL15] [RL16] precharge after active time
						s_nxt.cmdValid = 1'b1;
						s_nxt.cmdOp = TRS_PRE;
						s_nxt.cmdBank = s_r.seqBank;
						s_nxt.tmr = (s_r.step == TRS_SEQ_LAST) ? TRS_LD_RP_MRD : TRS_LD_RP;
						s_nxt.st = (s_r.step == TRS_SEQ_LAST) ? C_END : C_RP;
					end
					else
						s_nxt.tmr = s_r.tmr - 1'b1;
				end
				C_RP:
				begin
					if (s_r.tmr == '0)
					begin
						// [RL21] three activates only, spaced apart
						s_nxt.cmdValid = 1'b1;
						s_nxt.cmdOp = TRS_ACT;
						s_nxt.cmdBank = s_r.seqBank;
						s_nxt.cmdRow = s_r.seqRow;
						s_nxt.step = s_r.step + 1'b1;
						s_nxt.tmr = TRS_LD_RAS;
						s_nxt.st = C_RAS;
					end
					else
						s_nxt.tmr = s_r.tmr - 1'b1;
				end
				C_END:
				begin
					// [RL20] idle again only after precharge+delay
					if (s_r.tmr == '0)
					begin
						s_nxt.done = 1'b1;
						s_nxt.hits = 16'h0000;
						s_nxt.st = C_IDLE;
					end
					else
						s_nxt.tmr = s_r.tmr - 1'b1;
				end
				C_ABT_MRD, C_ABT_PRE:
				begin
					if (s_r.tmr != '0)
						s_nxt.tmr = s_r.tmr - 1'b1;
					else if (s_r.st == C_ABT_PRE && s_r.abtCnt == TRS_SEQ_ALL)
					begin
						// [RL17] rerun whole sequence
						s_nxt.cmdValid = 1'b1;
						s_nxt.cmdOp = TRS_MRW;
						s_nxt.cmdOperand = {1'b1, s_r.seqBank, link.modeReg[3:0]};
						s_nxt.step = 2'h0;
						s_nxt.tmr = TRS_LD_MRD;
						s_nxt.st = C_MRD;
					end
					else
					begin
						// [RL17] three spaced precharges
						s_nxt.cmdValid = 1'b1;
						s_nxt.cmdOp = TRS_PRE;
						s_nxt.cmdBank = s_r.seqBank;
						s_nxt.abtCnt = (s_r.st == C_ABT_MRD) ? 2'h1 : s_r.abtCnt + 1'b1;
						s_nxt.tmr = (s_r.abtCnt == TRS_SEQ_LAST) ? TRS_LD_RP_MRD : TRS_LD_RP;
						s_nxt.st = C_ABT_PRE;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// [RL18] no refresh is ever issued here
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	// outputs straight from the state register
	assign link.cmdValid   = s_r.cmdValid;
	assign link.cmdOp      = s_r.cmdOp;
	assign link.cmdBank    = s_r.cmdBank;
	assign link.cmdRow     = s_r.cmdRow;
	assign link.cmdOperand = s_r.cmdOperand;
	assign s_axi_awready   = s_r.awRdy;
	assign s_axi_wready    = s_r.wRdy;
	assign s_axi_bresp     = s_r.bResp;
	assign s_axi_bvalid    = s_r.bValid;
	assign s_axi_arready   = s_r.arRdy;
	assign s_axi_rdata     = s_r.rData;
	assign s_axi_rresp     = s_r.rResp;
	assign s_axi_rvalid    = s_r.rValid;

endmodule

/* File: trs_link_monitor.sv */
// concurrent checks on the command link between controller and device ends
`timescale 1ns/1ps
module trs_link_monitor
	import trs_pkg::*;
	(
		input wire logic        ref_clk,
		input wire logic        resetn,
		input wire logic        cmdValid,
		input wire trs_cmd_t    cmdOp,
		input wire logic [2:0]  cmdBank,
		input wire logic [7:0]  cmdOperand,
		input wire logic [7:0]  modeReg,
		input wire logic        modeActive,
		input wire logic [15:0] refreshCount,
		input wire logic        restoreValid,
		input wire logic [2:0]  restoreBank
	);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// entry and exit writes as seen on the link
	logic entryCmd;
	logic exitCmd;
	assign entryCmd = cmdValid && cmdOp == TRS_MRW && cmdOperand[7];
	assign exitCmd  = cmdValid && cmdOp == TRS_MRW && !cmdOperand[7];

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	// step commands on the selected bank, precharge-all counts too; s_anypre takes a precharge on any bank
	sequence s_act;
		cmdValid && cmdOp == TRS_ACT && cmdBank == modeReg[6:4];
	endsequence
	sequence s_pre;
		cmdValid && (cmdOp == TRS_PRECHARGE_EVERY_BANK || (cmdOp == TRS_PRE && cmdBank == modeReg[6:4]));
	endsequence
	sequence s_anypre;
		cmdValid && (cmdOp == TRS_PRE || cmdOp == TRS_PRECHARGE_EVERY_BANK);
	endsequence

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	// flow checks stand down on an exit write, which ends the attempt legally
	property p_entry;
		entryCmd && !modeActive |=> modeActive && modeReg[7:4] == {1'b1, $past(cmdOperand[6:4])};
	endproperty
	a_entry: assert property (p_entry) else $error("entry write did not arm mode");
	property p_exit;
		exitCmd |=> !modeActive && !modeReg[7];
	endproperty
	a_exit: assert property (p_exit) else $error("exit write did not clear mode");
	property p_mrd;
		disable iff (!resetn || exitCmd) entryCmd |=> !cmdValid ##1 s_act;
	endproperty
	a_mrd: assert property (p_mrd) else $error("link busy during mode delay");
	property p_first;
		disable iff (!resetn || exitCmd) entryCmd |-> ##2 s_act ##1 (!cmdValid)[*5] ##1 s_pre;
	endproperty
	a_first: assert property (p_first) else $error("first precharge mistimed");
	property p_second;
		disable iff (!resetn || exitCmd)
		entryCmd |-> ##8 s_pre ##2 s_act ##1 (!cmdValid)[*3] ##1 s_pre;
	endproperty
	a_second: assert property (p_second) else $error("second step spacing wrong");
	property p_third;
		disable iff (!resetn || exitCmd)
		entryCmd |-> ##14 s_pre ##2 s_act ##4 s_pre ##[3:5] $fell(modeActive);
	endproperty
	a_third: assert property (p_third) else $error("third step or clear wrong");
	property p_restore;
		restoreValid |-> !modeActive && $past(modeActive) && restoreBank == $past(modeReg[6:4]);
	endproperty
	a_restore: assert property (p_restore) else $error("restore pulse mistimed");
	property p_refcnt;
		modeActive |=> $stable(refreshCount);
	endproperty
	a_refcnt: assert property (p_refcnt) else $error("refresh counter moved in mode");
	property p_no_ref;
		modeActive |-> !(cmdValid && (cmdOp == TRS_REF || cmdOp == TRS_SREF));
	endproperty
	a_no_ref: assert property (p_no_ref) else $error("refresh issued in mode");
	property p_bank_only;
		modeActive && cmdValid && cmdOp == TRS_ACT |-> cmdBank == modeReg[6:4];
	endproperty
	a_bank_only: assert property (p_bank_only) else $error("other bank activated");
	property p_no_mrw;
		modeActive && cmdValid && cmdOp == TRS_MRW |-> !cmdOperand[7];
	endproperty
	a_no_mrw: assert property (p_no_mrw) else $error("mode write while active");
	property p_rerun;
		exitCmd && modeActive |-> ##2 s_anypre ##2 s_anypre ##2 s_anypre ##4 entryCmd;
	endproperty
	a_rerun: assert property (p_rerun) else $error("recovery sequence wrong");

endmodule

/* File: test_target_row_refresh_sequencer.sv */
// testbench: both ends joined, controller driven over its register bus
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
	begin \
		check_count++; \
		if ((got) !== (exp)) \
		begin \
			err_count++; \
			$display("ERROR %s expected %0h seen %0h", nm, exp, got); \
		end \
	end
module test_target_row_refresh_sequencer
	import trs_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        resetn = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [2:0]  lastBank;
	logic [15:0] lastRow;
	logic [7:0]  entryOp;
	int          err_count = 0, check_count = 0, cycles = 0;
	int          entryCount = 0, restoreCount = 0, k;

	trs_link_if link ();
	trs_dev_end trs_dev_end_inst (.ref_clk(ref_clk), .resetn(resetn), .link(link));
	// responses are always accepted, so the ready lines stay high
	trs_ctrl_end trs_ctrl_end_inst (.ref_clk(ref_clk), .resetn(resetn), .link(link),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1));
	trs_link_monitor trs_link_monitor_inst (.ref_clk(ref_clk), .resetn(resetn),
		.cmdValid(link.cmdValid), .cmdOp(link.cmdOp), .cmdBank(link.cmdBank),
		.cmdOperand(link.cmdOperand), .modeReg(link.modeReg), .modeActive(link.modeActive),
		.refreshCount(link.refreshCount), .restoreValid(link.restoreValid),
		.restoreBank(link.restoreBank));

	// ------------------------------------------------------------
	// clock, link watcher and hang guard
	// ------------------------------------------------------------
	always #5 ref_clk = ~ref_clk;

	// values read here are those from before the edge's updates
	always @(posedge ref_clk)
	begin
		cycles++;
		if (link.cmdValid === 1'b1 && link.cmdOp == TRS_MRW && link.cmdOperand[7] === 1'b1)
		begin
			entryCount++;
			entryOp = link.cmdOperand;
		end
		if (link.restoreValid === 1'b1)
		begin
			restoreCount++;
			lastBank = link.restoreBank;
			lastRow = link.restoreRow;
		end
		if (cycles == 5000)
		begin
			err_count++;
			test_done();
		end
	end

	// ------------------------------------------------------------
	// bus tasks
	// ------------------------------------------------------------
	// address and data offered together, each dropped when taken
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic awDone;
		logic wDone;
		awDone = 1'b0;
		wDone = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(awDone && wDone))
		begin
			@(posedge ref_clk);
			if (!awDone && awready === 1'b1) awvalid <= 1'b0;
			if (!wDone && wready === 1'b1) wvalid <= 1'b0;
			awDone = awDone || awready === 1'b1;
			wDone = wDone || wready === 1'b1;
		end
		do @(posedge ref_clk); while (bvalid !== 1'b1);
		`CHK("bresp", er, bresp)
	endtask

	// read one word and compare the bits under the mask
	task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
		input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge ref_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge ref_clk); while (rvalid !== 1'b1);
		`CHK("rdata", e, rdata & m)
		`CHK("rresp", er, rresp)
	endtask

	// bounded wait for the n-th completed sequence
	task automatic waitRestore(input int n);
		k = 0;
		while (restoreCount < n && k < 300)
		begin
			@(posedge ref_clk);
			k++;
		end
		`CHK("restores", n, restoreCount)
	endtask

	task automatic test_done();
		$display("TB: %0d checks, %0d errors", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (20) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rdChk(TRS_REG_STATUS, 32'h0000_0100, 32'hFFFF_FFFF, TRS_RESP_OKAY);
		rdChk(8'h20, 32'h0, 32'hFFFF_FFFF, TRS_RESP_SLVERR);
		axiWrite(8'h20, 32'h55, TRS_RESP_SLVERR);
		axiWrite(TRS_REG_ROW, 32'h1234, TRS_RESP_OKAY);
		rdChk(TRS_REG_ROW, 32'h1234, 32'h0000_FFFF, TRS_RESP_OKAY);
		// start before init is done must be dropped
		axiWrite(TRS_REG_CTRL, 32'h51, TRS_RESP_OKAY);
		repeat (30) @(posedge ref_clk);
		`CHK("entries", 0, entryCount)
		// plain run on bank 5
		axiWrite(TRS_REG_CTRL, 32'h54, TRS_RESP_OKAY);
		axiWrite(TRS_REG_CTRL, 32'h55, TRS_RESP_OKAY);
		waitRestore(1);
		`CHK("entry operand", 8'hD1, entryOp)
		`CHK("restore bank", 3'h5, lastBank)
		`CHK("restore row", 16'h1234, lastRow)
		repeat (4) @(posedge ref_clk);
		rdChk(TRS_REG_STATUS, 32'h0000_0102, 32'hFFFF_8FFF, TRS_RESP_OKAY);
		// abort in mid-sequence, then the rerun must complete
		axiWrite(TRS_REG_CTRL, 32'h5C, TRS_RESP_OKAY);
		axiWrite(TRS_REG_CTRL, 32'h55, TRS_RESP_OKAY);
		k = 0;
		while (link.modeActive !== 1'b1 && k < 20)
		begin
			@(posedge ref_clk);
			k++;
		end
		axiWrite(TRS_REG_CTRL, 32'h56, TRS_RESP_OKAY);
		waitRestore(2);
		`CHK("entries", 3, entryCount)
		repeat (4) @(posedge ref_clk);
		rdChk(TRS_REG_STATUS, 32'h0000_0106, 32'hFFFF_8FFF, TRS_RESP_OKAY);
		// activate count reaching the limit starts a run by itself
		axiWrite(TRS_REG_CTRL, 32'h5C, TRS_RESP_OKAY);
		axiWrite(TRS_REG_LIMIT, 32'h3, TRS_RESP_OKAY);
		axiWrite(TRS_REG_HITS, 32'h3, TRS_RESP_OKAY);
		waitRestore(3);
		`CHK("entries", 4, entryCount)
		repeat (4) @(posedge ref_clk);
		rdChk(TRS_REG_HITS, 32'h0, 32'hFFFF_FFFF, TRS_RESP_OKAY);
		test_done();
	end

endmodule
